/* rtl/capture_compare_module.sv */
// One capture/compare module: 16-bit value, mode register and match flag.
// Assumes decoded one-cycle write strobes from the parent register block.
`timescale 1ns/1ps
`default_nettype none
module capture_compare_module #(
  parameter bit LOCKABLE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic wr_mode,
  input wire logic [7:0] wdata,
  input wire logic watchdog_lock_enable,
  input wire logic [15:0] counter_value,
  input wire logic flag_clear,
  output logic [15:0] value_reg,
  output logic [7:0] mode_reg,
  output logic flag_reg
);
  logic match_now;
  logic mode_blocked;

  // ========================================================================
  // Value storage
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      value_reg <= counter_array_pkg::VALUE_RESET;
    else if (wr_low)
      value_reg[7:0] <= wdata;
    else if (wr_high)
      value_reg[15:8] <= wdata;
  end

  // ========================================================================
  // Mode register with comparator enable side effects
  assign mode_blocked = LOCKABLE && watchdog_lock_enable;
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      mode_reg <= counter_array_pkg::MODE_RESET;
    else if (wr_mode && !mode_blocked)
      mode_reg <= wdata;
    else if (wr_low)
      mode_reg[counter_array_pkg::MODE_COMPARATOR_BIT] <= 1'b0;
    else if (wr_high)
      mode_reg[counter_array_pkg::MODE_COMPARATOR_BIT] <= 1'b1;
  end

  // ========================================================================
  // Match flag, set wins over clear
  assign match_now = mode_reg[counter_array_pkg::MODE_MATCH_BIT]
    && mode_reg[counter_array_pkg::MODE_COMPARATOR_BIT]
    && (counter_value == value_reg);
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      flag_reg <= 1'b0;
    else if (match_now)
      flag_reg <= 1'b1;
    else if (flag_clear)
      flag_reg <= 1'b0;
  end

  // ========================================================================
  // Checks
  sequence seq_low_write;
    wr_low;
  endsequence
  sequence seq_high_write;
    wr_high && !wr_mode;
  endsequence

  AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    wr_low |=> value_reg[7:0] == $past(wdata))
    else $error("module low byte not stored");
  AST_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    wr_high && !wr_low |=> value_reg[15:8] == $past(wdata))
    else $error("module high byte not stored");
  AST_LOW_CLEARS_EN: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_low && !wr_mode |=> !mode_reg[counter_array_pkg::MODE_COMPARATOR_BIT])
    else $error("comparator enable not cleared by low write");
  AST_LOW_THEN_HIGH: assert property (@(posedge ref_clk)
    disable iff (reset)
    seq_low_write ##[1:4] seq_high_write
    |=> mode_reg[counter_array_pkg::MODE_COMPARATOR_BIT])
    else $error("comparator not enabled after low then high write");
  AST_MATCH_SETS: assert property (@(posedge ref_clk) disable iff (reset)
    match_now |=> flag_reg)
    else $error("match did not set flag");
  AST_FLAG_HOLDS: assert property (@(posedge ref_clk) disable iff (reset)
    flag_reg && !flag_clear |=> flag_reg)
    else $error("flag dropped without clear");
  AST_MODE_LOCK: assert property (@(posedge ref_clk) disable iff (reset)
    wr_mode && mode_blocked |=> mode_reg == $past(mode_reg))
    else $error("locked mode register changed");
  AST_HIGH_SETS_EN: assert property (@(posedge ref_clk)
    disable iff (reset)
    seq_high_write |=> mode_reg[counter_array_pkg::MODE_COMPARATOR_BIT])
    else $error("comparator enable not set by high write");
  AST_FLAG_CLEAR: assert property (@(posedge ref_clk)
    disable iff (reset)
    flag_clear && !match_now |=> !flag_reg)
    else $error("flag not cleared by clear request");
endmodule : capture_compare_module
`default_nettype wire

/* rtl/counter_array_capture_regs.sv */
// Counter array register block: counter, snapshot, five compare modules.
// Assumes an 8-bit SFR bus with one-cycle read and write strobes on ref_clk,
// and a counter tick and watchdog lock produced on the same clock.
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_regs #(
  parameter int MODULE_COUNT = counter_array_pkg::MODULE_COUNT
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic watchdog_lock_enable,
  input wire logic count_tick,
  input wire logic [MODULE_COUNT-1:0] flag_clear,
  output logic [7:0] sfr_rdata,
  output logic [15:0] counter_value,
  output logic [MODULE_COUNT-1:0] capture_compare_flag,
  output logic [MODULE_COUNT-1:0] comparator_function_enable
);
  // ========================================================================
  // Declarations
  logic [15:0] counter_reg;
  logic [7:0] snapshot_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic wr_counter_low;
  logic wr_counter_high;
  logic rd_counter_low;
  logic rd_counter_high;
  logic [MODULE_COUNT-1:0] wr_low;
  logic [MODULE_COUNT-1:0] wr_high;
  logic [MODULE_COUNT-1:0] wr_mode;
  logic [MODULE_COUNT-1:0] rd_low;
  logic [MODULE_COUNT-1:0] rd_high;
  logic [MODULE_COUNT-1:0] rd_mode;
  logic [15:0] value_bus [MODULE_COUNT];
  logic [7:0] mode_bus [MODULE_COUNT];
  logic addr_mapped;

  // ========================================================================
  // Counter address decode
  assign wr_counter_low = sfr_wr
    && (sfr_addr == counter_array_pkg::COUNTER_LOW_ADDR);
  assign wr_counter_high = sfr_wr
    && (sfr_addr == counter_array_pkg::COUNTER_HIGH_ADDR);
  assign rd_counter_low = sfr_rd
    && (sfr_addr == counter_array_pkg::COUNTER_LOW_ADDR);
  assign rd_counter_high = sfr_rd
    && (sfr_addr == counter_array_pkg::COUNTER_HIGH_ADDR);
  // Any decoded register, for the unmapped read check
  assign addr_mapped = (|{rd_low, rd_high, rd_mode})
    || (sfr_addr == counter_array_pkg::COUNTER_LOW_ADDR)
    || (sfr_addr == counter_array_pkg::COUNTER_HIGH_ADDR);

  // ========================================================================
  // Module address decode and instances
  genvar gi;
  generate
    for (gi = 0; gi < MODULE_COUNT; gi++)
    begin : g_module
      // Write strobes and read address decodes for this module's three registers
      assign wr_low[gi] = sfr_wr
        && (sfr_addr == counter_array_pkg::LOW_ADDRS[gi*8 +: 8]);
      assign wr_high[gi] = sfr_wr
        && (sfr_addr == counter_array_pkg::HIGH_ADDRS[gi*8 +: 8]);
      assign wr_mode[gi] = sfr_wr
        && (sfr_addr == counter_array_pkg::MODE_ADDRS[gi*8 +: 8]);
      assign rd_low[gi] = sfr_addr == counter_array_pkg::LOW_ADDRS[gi*8 +: 8];
      assign rd_high[gi] = sfr_addr == counter_array_pkg::HIGH_ADDRS[gi*8 +: 8];
      assign rd_mode[gi] = sfr_addr == counter_array_pkg::MODE_ADDRS[gi*8 +: 8];
      assign comparator_function_enable[gi] =
        mode_bus[gi][counter_array_pkg::MODE_COMPARATOR_BIT];

      capture_compare_module #(
        .LOCKABLE(gi == counter_array_pkg::WATCHDOG_MODULE)
      ) u_module (
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_low(wr_low[gi]),
        .wr_high(wr_high[gi]),
        .wr_mode(wr_mode[gi]),
        .wdata(sfr_wdata),
        .watchdog_lock_enable(watchdog_lock_enable),
        .counter_value(counter_reg),
        .flag_clear(flag_clear[gi]),
        .value_reg(value_bus[gi]),
        .mode_reg(mode_bus[gi]),
        .flag_reg(capture_compare_flag[gi])
      );

      // Read data of this module's three registers
      AST_MODULE_LOW_READ: assert property (@(posedge ref_clk)
        disable iff (reset)
        sfr_rd && rd_low[gi] |=> sfr_rdata == $past(value_bus[gi][7:0]))
        else $error("module low byte read wrong");
      AST_MODULE_HIGH_READ: assert property (@(posedge ref_clk)
        disable iff (reset)
        sfr_rd && rd_high[gi] |=> sfr_rdata == $past(value_bus[gi][15:8]))
        else $error("module high byte read wrong");
      AST_MODULE_MODE_READ: assert property (@(posedge ref_clk)
        disable iff (reset)
        sfr_rd && rd_mode[gi] |=> sfr_rdata == $past(mode_bus[gi]))
        else $error("module mode read wrong");
    end
  endgenerate

  // ========================================================================
  // Counter: software write unless locked, else count on tick
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      counter_reg <= counter_array_pkg::COUNTER_RESET;
    else if (wr_counter_low && !watchdog_lock_enable)
      counter_reg[7:0] <= sfr_wdata;
    else if (wr_counter_high && !watchdog_lock_enable)
      counter_reg[15:8] <= sfr_wdata;
    else if (count_tick)
      counter_reg <= counter_reg + 16'h0001;
  end
  assign counter_value = counter_reg;

  // ========================================================================
  // Snapshot of the upper byte, loaded on a low-byte read
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      snapshot_reg <= counter_array_pkg::SNAPSHOT_RESET;
    else if (rd_counter_low)
      snapshot_reg <= counter_reg[15:8];
  end

  // ========================================================================
  // Read multiplexer
  always_comb
  begin
    rdata_next = counter_array_pkg::UNMAPPED_READ;
    if (sfr_addr == counter_array_pkg::COUNTER_LOW_ADDR)
      rdata_next = counter_reg[7:0];
    else if (sfr_addr == counter_array_pkg::COUNTER_HIGH_ADDR)
      rdata_next = snapshot_reg;
    else
    begin
      for (int i = 0; i < MODULE_COUNT; i++)
      begin
        if (rd_low[i])
          rdata_next = value_bus[i][7:0];
        else if (rd_high[i])
          rdata_next = value_bus[i][15:8];
        else if (rd_mode[i])
          rdata_next = mode_bus[i];
      end
    end
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      rdata_reg <= counter_array_pkg::UNMAPPED_READ;
    else if (sfr_rd)
      rdata_reg <= rdata_next;
  end
  assign sfr_rdata = rdata_reg;

  // ========================================================================
  // Checks
  sequence seq_low_read;
    rd_counter_low;
  endsequence
  sequence seq_high_read;
    rd_counter_high;
  endsequence

  AST_LOW_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    wr_counter_low && !watchdog_lock_enable
    |=> counter_reg[7:0] == $past(sfr_wdata))
    else $error("counter low byte not written");
  AST_HIGH_WRITE: assert property (@(posedge ref_clk) disable iff (reset)
    wr_counter_high && !watchdog_lock_enable
    |=> counter_reg[15:8] == $past(sfr_wdata))
    else $error("counter high byte not written");
  AST_SNAPSHOT_LOAD: assert property (@(posedge ref_clk)
    disable iff (reset)
    seq_low_read |=> snapshot_reg == $past(counter_reg[15:8]))
    else $error("snapshot not loaded on low read");
  AST_SNAPSHOT_HOLD: assert property (@(posedge ref_clk)
    disable iff (reset)
    !rd_counter_low |=> $stable(snapshot_reg))
    else $error("snapshot changed without low read");
  AST_LOW_THEN_HIGH_READ: assert property (@(posedge ref_clk)
    disable iff (reset)
    seq_low_read ##[1:5] seq_high_read
    |=> sfr_rdata == $past(snapshot_reg))
    else $error("high read did not return snapshot");
  AST_LOW_LOCKED: assert property (@(posedge ref_clk) disable iff (reset)
    wr_counter_low && watchdog_lock_enable && !count_tick
    |=> $stable(counter_reg))
    else $error("locked counter low byte changed");
  AST_HIGH_LOCKED: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_counter_high && watchdog_lock_enable && !count_tick
    |=> $stable(counter_reg))
    else $error("locked counter high byte changed");
  AST_COUNT_TICK: assert property (@(posedge ref_clk) disable iff (reset)
    count_tick && !wr_counter_low && !wr_counter_high
    |=> counter_reg == $past(counter_reg) + 16'h0001)
    else $error("counter did not advance on tick");
  AST_LOW_READ_DATA: assert property (@(posedge ref_clk)
    disable iff (reset)
    seq_low_read |=> sfr_rdata == $past(counter_reg[7:0]))
    else $error("low read returned wrong byte");
  AST_HIGH_READ_DATA: assert property (@(posedge ref_clk)
    disable iff (reset)
    seq_high_read |=> sfr_rdata == $past(snapshot_reg))
    else $error("high read did not return the snapshot");
  AST_LOW_KEEPS_HIGH: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_counter_low && !watchdog_lock_enable
    |=> counter_reg[15:8] == $past(counter_reg[15:8]))
    else $error("counter low write disturbed the high byte");
  AST_HIGH_KEEPS_LOW: assert property (@(posedge ref_clk)
    disable iff (reset)
    wr_counter_high && !watchdog_lock_enable
    |=> counter_reg[7:0] == $past(counter_reg[7:0]))
    else $error("counter high write disturbed the low byte");
  AST_LOCKED_STILL_COUNTS: assert property (@(posedge ref_clk)
    disable iff (reset)
    (wr_counter_low || wr_counter_high) && watchdog_lock_enable && count_tick
    |=> counter_reg == $past(counter_reg) + 16'h0001)
    else $error("locked write stopped the count");
  AST_COUNTER_IDLE: assert property (@(posedge ref_clk)
    disable iff (reset)
    !count_tick && !wr_counter_low && !wr_counter_high
    |=> $stable(counter_reg))
    else $error("counter moved with no tick or write");

  // Read data register behaviour
  AST_READ_HOLDS: assert property (@(posedge ref_clk) disable iff (reset)
    !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data changed without a read");
  AST_UNMAPPED_READ: assert property (@(posedge ref_clk) disable iff (reset)
    sfr_rd && !addr_mapped
    |=> sfr_rdata == counter_array_pkg::UNMAPPED_READ)
    else $error("unmapped read returned nonzero data");
endmodule : counter_array_capture_regs
`default_nettype wire

/* rtl/counter_array_pkg.sv */
// Constants for the counter array register block: addresses, fields, resets.
// Assumes an 8-bit special-function-register bus on one system clock.
//
// Behaviour
// - A 16-bit counter, low and high bytes readable and writable.
// - High byte reads a snapshot taken when the low byte is read.
// - Low byte writes ignored while the watchdog lock is set.
// - High byte writes ignored while the watchdog lock is set.
// - Five modules hold a 16-bit value; low byte reachable.
// - Module value high byte readable and writable.
// - Writing a module low byte clears its comparator enable.
// - Writing a module high byte sets its comparator enable.
// - Enabled match with counter equal to value sets the module flag.
// - Under watchdog lock, module 4 mode register writes are blocked.
// ==========================================================================
// Package
package counter_array_pkg;
  localparam int MODULE_COUNT = 5;
  localparam int WATCHDOG_MODULE = 4;
  // Counter addresses
  localparam logic [7:0] COUNTER_LOW_ADDR = 8'hf9;
  localparam logic [7:0] COUNTER_HIGH_ADDR = 8'hfa;
  // Module value addresses
  localparam logic [7:0] MODULE0_LOW_ADDR = 8'hfb;
  localparam logic [7:0] MODULE0_HIGH_ADDR = 8'hfc;
  localparam logic [7:0] MODULE1_LOW_ADDR = 8'he9;
  localparam logic [7:0] MODULE1_HIGH_ADDR = 8'hea;
  localparam logic [7:0] MODULE2_LOW_ADDR = 8'heb;
  localparam logic [7:0] MODULE2_HIGH_ADDR = 8'hec;
  localparam logic [7:0] MODULE3_LOW_ADDR = 8'hed;
  localparam logic [7:0] MODULE3_HIGH_ADDR = 8'hee;
  localparam logic [7:0] MODULE4_LOW_ADDR = 8'hfd;
  localparam logic [7:0] MODULE4_HIGH_ADDR = 8'hfe;
  // Module mode addresses
  localparam logic [7:0] MODULE0_MODE_ADDR = 8'hda;
  localparam logic [7:0] MODULE1_MODE_ADDR = 8'hdb;
  localparam logic [7:0] MODULE2_MODE_ADDR = 8'hdc;
  localparam logic [7:0] MODULE3_MODE_ADDR = 8'hdd;
  localparam logic [7:0] MODULE4_MODE_ADDR = 8'hde;
  // Address tables indexed by module number
  localparam logic [39:0] LOW_ADDRS = {MODULE4_LOW_ADDR, MODULE3_LOW_ADDR,
    MODULE2_LOW_ADDR, MODULE1_LOW_ADDR, MODULE0_LOW_ADDR};
  localparam logic [39:0] HIGH_ADDRS = {MODULE4_HIGH_ADDR, MODULE3_HIGH_ADDR,
    MODULE2_HIGH_ADDR, MODULE1_HIGH_ADDR, MODULE0_HIGH_ADDR};
  localparam logic [39:0] MODE_ADDRS = {MODULE4_MODE_ADDR, MODULE3_MODE_ADDR,
    MODULE2_MODE_ADDR, MODULE1_MODE_ADDR, MODULE0_MODE_ADDR};
  // Mode register fields
  localparam int MODE_COMPARATOR_BIT = 6;
  localparam int MODE_MATCH_BIT = 3;
  // Reset values
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] SNAPSHOT_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : counter_array_pkg

/* testbench/tb.sv */
// Self-checking bench for the counter array register block.
// Assumes the block's SFR strobes are sampled on the rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic watchdog_lock_enable = 1'b0;
  logic count_tick = 1'b0;
  logic [4:0] flag_clear = 5'h00;
  logic [7:0] sfr_rdata;
  logic [15:0] counter_value;
  logic [4:0] capture_compare_flag;
  logic [4:0] comparator_function_enable;
  int fails = 0;
  int check_count = 0;
  int cycles = 0;

  // =========================================================================
  // Clock, device and run limit
  // Clock at 25 ns period
  initial
  begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  counter_array_capture_regs #(.MODULE_COUNT(5)) u_dut (
    .ref_clk(ref_clk),
    .reset(reset),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .watchdog_lock_enable(watchdog_lock_enable),
    .count_tick(count_tick),
    .flag_clear(flag_clear),
    .sfr_rdata(sfr_rdata),
    .counter_value(counter_value),
    .capture_compare_flag(capture_compare_flag),
    .comparator_function_enable(comparator_function_enable)
  );

  // Hang guard: far above the roughly 130 cycles the tests need
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      fails = fails + 1;
      report_and_stop();
    end
  end

  // =========================================================================
  // Bus and compare tasks
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One write strobe, dropped at the following falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
  endtask : wr

  // Read strobe, data sampled at the falling edge half a cycle after the taking edge
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge ref_clk);
    sfr_rd = 1'b0;
    chk($sformatf("read %h", a), {8'h00, sfr_rdata}, {8'h00, exp});
  endtask : rchk

  task automatic tick();
    @(negedge ref_clk);
    count_tick = 1'b1;
    @(negedge ref_clk);
    count_tick = 1'b0;
  endtask : tick

  // =========================================================================
  // Scenarios
  // Counter and module value registers read zero after reset, unmapped too
  task automatic reset_values();
    for (int m = 0; m < 5; m++)
    begin
      rchk(counter_array_pkg::LOW_ADDRS[m*8 +: 8], 8'h00);
      rchk(counter_array_pkg::HIGH_ADDRS[m*8 +: 8], 8'h00);
    end
    rchk(counter_array_pkg::COUNTER_LOW_ADDR, 8'h00);
    rchk(counter_array_pkg::COUNTER_HIGH_ADDR, 8'h00);
    rchk(8'h80, counter_array_pkg::UNMAPPED_READ);
  endtask : reset_values

  // Byte writes, snapshot held across a high byte change, wrap
  task automatic counter_bytes();
    wr(8'hf9, 8'h34);
    wr(8'hfa, 8'h12);
    chk("counter", counter_value, 16'h1234);
    rchk(8'hf9, 8'h34);
    wr(8'hfa, 8'h56);
    rchk(8'hfa, 8'h12);
    rchk(8'hf9, 8'h34);
    rchk(8'hfa, 8'h56);
    wr(8'hf9, 8'hff);
    wr(8'hfa, 8'hff);
    tick();
    chk("counter wrap", counter_value, 16'h0000);
  endtask : counter_bytes

  // Counter writes dropped under the watchdog lock
  task automatic counter_lock();
    watchdog_lock_enable = 1'b1;
    wr(8'hf9, 8'haa);
    chk("locked low", counter_value, 16'h0000);
    wr(8'hfa, 8'hbb);
    chk("locked high", counter_value, 16'h0000);
    watchdog_lock_enable = 1'b0;
  endtask : counter_lock

  // Write beats a same-cycle tick; under the lock the tick still counts
  task automatic tick_priority();
    @(negedge ref_clk);
    sfr_addr = counter_array_pkg::COUNTER_LOW_ADDR;
    sfr_wdata = 8'h77;
    sfr_wr = 1'b1;
    count_tick = 1'b1;
    @(negedge ref_clk);
    chk("write over tick", counter_value, 16'h0077);
    watchdog_lock_enable = 1'b1;
    sfr_wdata = 8'h99;
    @(negedge ref_clk);
    sfr_wr = 1'b0;
    count_tick = 1'b0;
    watchdog_lock_enable = 1'b0;
    chk("locked tick", counter_value, 16'h0078);
  endtask : tick_priority

  // Each module: value bytes and the enable side effects
  task automatic module_values();
    logic [7:0] la;
    logic [7:0] ha;
    for (int m = 0; m < 5; m++)
    begin
      la = counter_array_pkg::LOW_ADDRS[m*8 +: 8];
      ha = counter_array_pkg::HIGH_ADDRS[m*8 +: 8];
      wr(ha, 8'h20);
      chk("enable set", 16'(comparator_function_enable[m]), 16'h1);
      wr(la, 8'h10 + 8'(m));
      chk("enable clr", 16'(comparator_function_enable[m]), 16'h0);
      wr(ha, 8'h20 + 8'(m));
      chk("enable again", 16'(comparator_function_enable[m]), 16'h1);
      rchk(la, 8'h10 + 8'(m));
      rchk(ha, 8'h20 + 8'(m));
    end
  endtask : module_values

  // Module 4 mode register frozen under the lock
  task automatic mode_lock();
    watchdog_lock_enable = 1'b1;
    wr(counter_array_pkg::MODULE4_MODE_ADDR, 8'h00);
    chk("mode4 locked", 16'(comparator_function_enable[4]), 16'h1);
    rchk(counter_array_pkg::MODULE4_MODE_ADDR, 8'h40);
    watchdog_lock_enable = 1'b0;
    wr(counter_array_pkg::MODULE4_MODE_ADDR, 8'h00);
    chk("mode4 free", {15'h0000, comparator_function_enable[4]}, 16'h0);
  endtask : mode_lock

  // Match of module 0 at 0x0005, then clear after the count moves on
  task automatic match_flag();
    wr(counter_array_pkg::MODULE0_LOW_ADDR, 8'h05);
    wr(counter_array_pkg::MODULE0_HIGH_ADDR, 8'h00);
    wr(counter_array_pkg::MODULE0_MODE_ADDR, 8'h48);
    wr(8'hf9, 8'h03);
    wr(8'hfa, 8'h00);
    tick();
    chk("flag early", {11'h000, capture_compare_flag}, 16'h0000);
    tick();
    @(negedge ref_clk);
    chk("flag on match", {15'h0000, capture_compare_flag[0]}, 16'h1);
    // Clear while the match still stands: the set wins
    flag_clear = 5'h01;
    @(negedge ref_clk);
    flag_clear = 5'h00;
    chk("set over clear", 16'(capture_compare_flag[0]), 16'h1);
    tick();
    flag_clear = 5'h01;
    @(negedge ref_clk);
    flag_clear = 5'h00;
    chk("flag cleared", {15'h0000, capture_compare_flag[0]}, 16'h0);
  endtask : match_flag

  // =========================================================================
  // Main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk);
    reset = 1'b0;
    reset_values();
    counter_bytes();
    counter_lock();
    tick_priority();
    module_values();
    mode_lock();
    match_flag();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
